// File: hw/ccr_params.svh
// offsets, field positions, reset values and timing for the control bank
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
`define CCR_BASE_ADDR 7'h4C
`define CCR_GC_OFFSET 8'hB0
`define CCR_BFR_OFFSET 8'hB1
`define CCR_GC_RESET 8'h00
`define CCR_BFR_RESET 8'h00
`define CCR_GC_INDIV 7
`define CCR_GC_CLEAR 6
`define CCR_GC_INV 5
`define CCR_GC_TRACK 4
`define CCR_RESTART_MS 500
`define CCR_CLOCK_KHZ 25000
`define CCR_RESTART_CYCLES (`CCR_RESTART_MS * `CCR_CLOCK_KHZ)
`endif

// File: hw/ccr_pkg.sv
// types for the converter control register bank
package ccr_pkg;
  typedef enum logic [3:0] {
    ccr_idle, ccr_addr, ccr_addr_ack, ccr_cmd, ccr_cmd_ack,
    ccr_wdata, ccr_wdata_ack, ccr_rdata, ccr_rdata_ack
  } ccr_bus_state_type;
  typedef enum logic [1:0] {
    ccr_resp_flag, ccr_resp_hiccup, ccr_resp_latch
  } ccr_resp_type;
  typedef struct packed {
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic [3:0] flt_s1, flt_s2;
    logic mode_s1, mode_s2, swen_s1, swen_s2;
    logic [1:0] strap_s1, strap_s2, role;
    logic [1:0] boot;
    logic role_done;
    ccr_bus_state_type st;
    logic [3:0] cnt;
    logic [7:0] shift, cmd;
    logic rw, sda_low;
    logic [7:0] gc, bfr;
    logic [3:0] status;
    logic latched;
    logic [23:0] hic_cnt;
    logic alert_oe_n, stop;
    logic [5:0] phase, phase_mid;
    logic trk;
  } ccr_state_type;
endpackage

// File: hw/ccr_top.sv
// converter control register bank with its management-bus slave
`timescale 1ns/1ps
`include "ccr_params.svh"
// Overview of operation
// - The bus address is 0x4C plus the role: master, slave one to three.
// - The role is caught once from the address strap after reset.
// - General control is a byte register, read and write, reset zero.
// - Bit 7 picks per-fault fields over the mode strap response.
// - While bit 6 is one all status clears, else new faults are kept.
// - When bit 6 falls a fault still present sets its status again.
// - Polarity zero drives high for high-side on and low-side off.
// - Polarity one drives high for high-side off and low-side on.
// - The middle level means both switches off in either polarity.
// - Bit 4 picks digital tracking at zero and analog at one.
// - Fault response register holds four 2-bit fields, reset zero.
// - Field 00 and 11 flag, 01 stops and restarts, 10 latches off.
// - A fault sets status and pulls alert low until all status clears.
module ccr_top import ccr_pkg::*; #(
  parameter logic [23:0] RESTART_CYCLES = 24'(`CCR_RESTART_CYCLES)
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic [1:0] i_addr_strap,
  input wire logic i_mode_latch_off,
  input wire logic i_switch_enable,
  input wire logic [3:0] i_fault_detect,
  input wire logic [5:0] i_phase_cmd,
  input wire logic [5:0] i_phase_both_off,
  output logic [5:0] o_phase_drive_output,
  output logic [5:0] o_phase_drive_output_mid,
  output logic o_tracking_source_select,
  output logic o_switching_stop,
  output logic [3:0] o_fault_status,
  output logic o_fault_alert_output_out,
  output logic o_fault_alert_output_oe_n
);

  ccr_state_type state_reg;
  ccr_state_type state_next;
  logic scl_rise, scl_fall, bus_start, bus_stop, addr_hit;
  logic [7:0] rd_byte;
  logic [6:0] my_addr;
  ccr_resp_type resp [4];
  logic [3:0] hic_hit, latch_hit;

  // decode of one 2-bit response field
  function automatic ccr_resp_type ccr_decode(input logic [1:0] f);
    ccr_resp_type r;
    r = ccr_resp_flag;
    unique case (f)
      2'h1: r = ccr_resp_hiccup;
      2'h2: r = ccr_resp_latch;
      default: r = ccr_resp_flag;
    endcase
    return r;
  endfunction

  // bus edges, address match and read data
  always_comb begin
    scl_rise = state_reg.scl_s2 & ~state_reg.scl_s3;
    scl_fall = ~state_reg.scl_s2 & state_reg.scl_s3;
    // start and stop are data edges while the clock stays high
    bus_start = state_reg.scl_s2 & state_reg.scl_s3 &
                ~state_reg.sda_s2 & state_reg.sda_s3;
    bus_stop = state_reg.scl_s2 & state_reg.scl_s3 &
               state_reg.sda_s2 & ~state_reg.sda_s3;
    my_addr = `CCR_BASE_ADDR + {5'h00, state_reg.role};
    addr_hit = state_reg.role_done & (state_reg.shift[7:1] == my_addr);
    // read mux, unmapped commands read as zero
    if (state_reg.cmd == `CCR_GC_OFFSET) begin
      rd_byte = state_reg.gc;
    end else if (state_reg.cmd == `CCR_BFR_OFFSET) begin
      rd_byte = state_reg.bfr;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // effective response per fault
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (state_reg.gc[`CCR_GC_INDIV]) begin
        resp[i] = ccr_decode(state_reg.bfr[2*i +: 2]);
      end else if (state_reg.mode_s2) begin
        resp[i] = ccr_resp_latch;
      end else begin
        resp[i] = ccr_resp_hiccup;
      end
      // which present faults stop switching, and how
      hic_hit[i] = state_reg.flt_s2[i] & (resp[i] == ccr_resp_hiccup);
      latch_hit[i] = state_reg.flt_s2[i] & (resp[i] == ccr_resp_latch);
    end
  end

  // next-state logic
  always_comb begin
    state_next = state_reg;
    // pin synchronisers
    state_next.scl_s1 = i_scl;
    state_next.scl_s2 = state_reg.scl_s1;
    state_next.scl_s3 = state_reg.scl_s2;
    state_next.sda_s1 = i_sda;
    state_next.sda_s2 = state_reg.sda_s1;
    state_next.sda_s3 = state_reg.sda_s2;
    state_next.flt_s1 = i_fault_detect;
    state_next.flt_s2 = state_reg.flt_s1;
    state_next.mode_s1 = i_mode_latch_off;
    state_next.mode_s2 = state_reg.mode_s1;
    state_next.swen_s1 = i_switch_enable;
    state_next.swen_s2 = state_reg.swen_s1;
    state_next.strap_s1 = i_addr_strap;
    state_next.strap_s2 = state_reg.strap_s1;
    // wait two edges so the strap has crossed both sync stages
    // role caught once
    if (!state_reg.role_done) begin
      if (state_reg.boot == 2'h2) begin
        state_next.role = state_reg.strap_s2;
        state_next.role_done = 1'b1;
      end else begin
        state_next.boot = state_reg.boot + 2'h1;
      end
    end

    // bus slave
    if (bus_start) begin
      state_next.st = ccr_addr;
      state_next.cnt = 4'h0;
      state_next.sda_low = 1'b0;
    end else if (bus_stop) begin
      state_next.st = ccr_idle;
      state_next.sda_low = 1'b0;
    end else begin
      unique case (state_reg.st)
        // idle waits for the next start
        ccr_idle: begin
          state_next.sda_low = 1'b0;
        end
        // shift a bit in on each clock rise, ack after the eighth
        ccr_addr, ccr_cmd, ccr_wdata: begin
          if (scl_rise) begin
            state_next.shift = {state_reg.shift[6:0], state_reg.sda_s2};
            state_next.cnt = state_reg.cnt + 4'h1;
          end else if (scl_fall && state_reg.cnt == 4'h8) begin
            state_next.sda_low = 1'b1;
            if (state_reg.st == ccr_addr) begin
              state_next.rw = state_reg.shift[0];
              state_next.st = addr_hit ? ccr_addr_ack : ccr_idle;
              state_next.sda_low = addr_hit;
            end else if (state_reg.st == ccr_cmd) begin
              state_next.cmd = state_reg.shift;
              state_next.st = ccr_cmd_ack;
            end else begin
              if (state_reg.cmd == `CCR_GC_OFFSET) begin
                state_next.gc = state_reg.shift;
              end
              if (state_reg.cmd == `CCR_BFR_OFFSET) begin
                state_next.bfr = state_reg.shift;
              end
              state_next.st = ccr_wdata_ack;
            end
          end
        end
        // after the address ack, turn round for a read
        ccr_addr_ack: begin
          if (scl_fall) begin
            state_next.cnt = 4'h0;
            if (state_reg.rw) begin
              state_next.shift = rd_byte;
              state_next.sda_low = ~rd_byte[7];
              state_next.st = ccr_rdata;
            end else begin
              state_next.sda_low = 1'b0;
              state_next.st = ccr_cmd;
            end
          end
        end
        ccr_cmd_ack, ccr_wdata_ack: begin
          if (scl_fall) begin
            state_next.cnt = 4'h0;
            state_next.sda_low = 1'b0;
            state_next.st = ccr_wdata;
          end
        end
        // read data changes only while the clock is low
        ccr_rdata: begin
          if (scl_rise) begin
            state_next.cnt = state_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (state_reg.cnt == 4'h8) begin
              state_next.sda_low = 1'b0;
              state_next.st = ccr_rdata_ack;
            end else begin
              state_next.shift = {state_reg.shift[6:0], 1'b0};
              state_next.sda_low = ~state_reg.shift[6];
            end
          end
        end
        // master ack asks for the same register again
        ccr_rdata_ack: begin
          if (scl_rise) begin
            state_next.rw = ~state_reg.sda_s2;
          end else if (scl_fall) begin
            state_next.cnt = 4'h0;
            if (state_reg.rw) begin
              state_next.shift = rd_byte;
              state_next.sda_low = ~rd_byte[7];
              state_next.st = ccr_rdata;
            end else begin
              state_next.st = ccr_idle;
            end
          end
        end
        default: begin
          state_next.st = ccr_idle;
          state_next.sda_low = 1'b0;
        end
      endcase
    end

    // clear wins for as long as it is held
    // clear holds status at zero
    if (state_reg.gc[`CCR_GC_CLEAR]) begin
      state_next.status = 4'h0;
    end else begin
      state_next.status = state_reg.status | state_reg.flt_s2;
    end
    state_next.alert_oe_n = ~|state_next.status;

    if (!state_reg.swen_s2) begin
      state_next.latched = 1'b0;
    end else if (|latch_hit) begin
      state_next.latched = 1'b1;
    end
    if (|hic_hit) begin
      state_next.hic_cnt = RESTART_CYCLES;
    end else if (state_reg.hic_cnt != 24'h0) begin
      state_next.hic_cnt = state_reg.hic_cnt - 24'h1;
    end
    state_next.stop = state_next.latched | (state_next.hic_cnt != 24'h0) |
                      ~state_reg.swen_s2;

    // phase drive with polarity and middle level
    for (int i = 0; i < 6; i++) begin
      state_next.phase[i] = i_phase_cmd[i] ^ state_reg.gc[`CCR_GC_INV];
      state_next.phase_mid[i] = i_phase_both_off[i] | state_reg.stop;
    end
    state_next.trk = state_reg.gc[`CCR_GC_TRACK];
  end

  // state register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
      // bus lines idle high, so no false edge after reset
      state_reg.scl_s1 <= 1'b1;
      state_reg.scl_s2 <= 1'b1;
      state_reg.scl_s3 <= 1'b1;
      state_reg.sda_s1 <= 1'b1;
      state_reg.sda_s2 <= 1'b1;
      state_reg.sda_s3 <= 1'b1;
      state_reg.st <= ccr_idle;
      state_reg.gc <= `CCR_GC_RESET;
      state_reg.bfr <= `CCR_BFR_RESET;
      state_reg.alert_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  // open-drain pins only ever pull low
  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = ~state_reg.sda_low;
  assign o_phase_drive_output = state_reg.phase;
  assign o_phase_drive_output_mid = state_reg.phase_mid;
  assign o_tracking_source_select = state_reg.trk;
  assign o_switching_stop = state_reg.stop;
  assign o_fault_status = state_reg.status;
  assign o_fault_alert_output_out = 1'b0;
  assign o_fault_alert_output_oe_n = state_reg.alert_oe_n;

endmodule

// File: verif/ccr_top_assertions.sv
// port checker for the control bank
`timescale 1ns/1ps
module ccr_top_assertions (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_switch_enable,
  input wire logic [3:0] i_fault_detect,
  input wire logic [5:0] i_phase_cmd,
  input wire logic [5:0] i_phase_both_off,
  input wire logic o_sda_oe_n,
  input wire logic [5:0] o_phase_drive_output,
  input wire logic [5:0] o_phase_drive_output_mid,
  input wire logic o_switching_stop,
  input wire logic [3:0] o_fault_status,
  input wire logic o_fault_alert_output_out,
  input wire logic o_fault_alert_output_oe_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // alert follows status, status only from a present fault
  chk_alert_status: assert property (o_fault_alert_output_oe_n ==
    (o_fault_status == 4'h0)) else $error("alert level wrong");
  chk_alert_drain: assert property (o_fault_alert_output_out == 1'b0)
    else $error("alert pin driven high");
  chk_status_cause: assert property ((o_fault_status &
    ~$past(o_fault_status) & ~($past(i_fault_detect, 2) |
    $past(i_fault_detect, 3))) == 4'h0) else $error("status without fault");
  chk_reset_quiet: assert property (disable iff (1'b0) !i_rst_n |->
    o_fault_status == 4'h0) else $error("status in reset");
  // phase polarity and middle level
  chk_phase_pol: assert property ($past(i_rst_n) |->
    (o_phase_drive_output == $past(i_phase_cmd) ||
    o_phase_drive_output == ~$past(i_phase_cmd))) else $error("phase");
  chk_phase_mid: assert property ($past(i_rst_n) |->
    ($past(i_phase_both_off) & ~o_phase_drive_output_mid) == 6'h00)
    else $error("middle level lost");
  chk_stop_enable: assert property (!i_switch_enable [*4] |=>
    o_switching_stop) else $error("no stop with enable low");
  chk_ack_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl)
    else $error("data driven while clock high");
endmodule

// File: verif/ccr_host.sv
// management bus host model, open-drain data with pull-up
`timescale 1ns/1ps
module ccr_host (
  input wire logic i_clock,
  input wire logic i_dev_sda_oe_n,
  input wire logic i_dev_sda_out,
  output logic o_scl,
  output logic o_sda
);
  logic sda_m = 1'b1;
  initial o_scl = 1'b1;
  // wired level of the data line
  assign o_sda = sda_m & (i_dev_sda_oe_n | i_dev_sda_out);
  task automatic half();
    repeat (6) @(posedge i_clock);
  endtask
  // start or repeated start, data released, clock set high, then data falls while clock high
  task automatic start();
    sda_m <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    sda_m <= 1'b0;
    half();
    o_scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    sda_m <= 1'b1;
    half();
  endtask
  // eight bits msb first, then the ninth acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic rel,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda_m <= (i < 0) ? rel : tx[i];
      half();
      o_scl <= 1'b1;
      half();
      if (i < 0) ack = !o_sda;
      else rx[i] = o_sda;
      o_scl <= 1'b0;
      half();
    end
  endtask
endmodule

// File: verif/tb_ccr_top.sv
// testbench for the control register bank
`timescale 1ns/1ps
module tb_ccr_top;
  logic i_clock = 1'b0;
  logic rst_n = 1'b1; // falls at time zero so the async reset fires
  logic [1:0] strap = 2'h0;
  logic mode = 1'b0;
  logic swen = 1'b1;
  logic [3:0] flt = 4'h0;
  logic [5:0] cmd = 6'h00;
  logic [5:0] boff = 6'h00;
  logic [6:0] dev = 7'h4F;
  logic [7:0] rx;
  logic ack;
  wire scl, sda, s_out, s_oe_n, trk, stp, a_out, a_oe_n;
  wire [5:0] ph, mid;
  wire [3:0] sts;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  initial forever #20 i_clock = ~i_clock;
  ccr_top #(.RESTART_CYCLES(24'h000010)) dut_u (.i_clock(i_clock),
    .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(s_out),
    .o_sda_oe_n(s_oe_n), .i_addr_strap(strap), .i_mode_latch_off(mode),
    .i_switch_enable(swen), .i_fault_detect(flt), .i_phase_cmd(cmd),
    .i_phase_both_off(boff), .o_phase_drive_output(ph),
    .o_phase_drive_output_mid(mid), .o_tracking_source_select(trk),
    .o_switching_stop(stp), .o_fault_status(sts),
    .o_fault_alert_output_out(a_out), .o_fault_alert_output_oe_n(a_oe_n));
  ccr_host host_u (.i_clock(i_clock), .i_dev_sda_oe_n(s_oe_n),
    .i_dev_sda_out(s_out), .o_scl(scl), .o_sda(sda));
  task automatic complete_run();
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // bus transactions: write, read with compare, address probe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.start();
    host_u.xfer({dev, 1'b0}, 1'b1, rx, ack);
    host_u.xfer(a, 1'b1, rx, ack);
    host_u.xfer(d, 1'b1, rx, ack);
    host_u.stop();
  endtask
  // point at a register, then turn round with a repeated start
  task automatic aim(input logic [7:0] a);
    host_u.start();
    host_u.xfer({dev, 1'b0}, 1'b1, rx, ack);
    host_u.xfer(a, 1'b1, rx, ack);
    host_u.start();
    host_u.xfer({dev, 1'b1}, 1'b1, rx, ack);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    aim(a);
    host_u.xfer(8'hFF, 1'b1, rx, ack);
    host_u.stop();
    chk($sformatf("reg %h", a), e, rx);
  endtask
  // two bytes in one read, master ack asks for the register again
  task automatic rd_two(input logic [7:0] a, input logic [7:0] e);
    aim(a);
    host_u.xfer(8'hFF, 1'b0, rx, ack);
    chk($sformatf("reg %h first", a), e, rx);
    host_u.xfer(8'hFF, 1'b1, rx, ack);
    host_u.stop();
    chk($sformatf("reg %h second", a), e, rx);
  endtask
  task automatic probe(input logic [6:0] d, input logic e);
    host_u.start();
    host_u.xfer({d, 1'b0}, 1'b1, rx, ack);
    host_u.stop();
    chk($sformatf("ack %h", d), {7'h00, e}, {7'h00, ack});
  endtask
  // hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    // each role answers at its own address, strap caught once
    for (int r = 0; r < 4; r++) begin
      rst_n <= 1'b0;
      strap <= 2'(r);
      wt(4);
      rst_n <= 1'b1;
      wt(8);
      strap <= 2'(r + 1);
      wt(8);
      probe(7'h4C + 7'(r), 1'b1);
      probe(7'h4C + 7'((r + 1) % 4), 1'b0);
    end
    rd(8'hB0, 8'h00);
    rd(8'hB1, 8'h00);
    cmd <= 6'h2D;
    boff <= 6'h01;
    wr(8'hB0, 8'h2F);
    rd(8'hB0, 8'h2F);
    chk("phase", 8'h12, {2'h0, ph});
    chk("mid", 8'h01, {2'h0, mid});
    chk("track", 8'h00, {7'h00, trk});
    wr(8'hB0, 8'h10);
    chk("phase", 8'h2D, {2'h0, ph});
    chk("mid", 8'h01, {2'h0, mid});
    chk("track", 8'h01, {7'h00, trk});
    wr(8'hB1, 8'hE4);
    rd_two(8'hB1, 8'hE4);
    wr(8'hB2, 8'hFF);
    rd(8'hB2, 8'h00);
    rd(8'hB0, 8'h10);
    flt <= 4'h2;
    wt(8);
    chk("status", 8'h02, {4'h0, sts});
    chk("alert", 8'h00, {7'h00, a_oe_n});
    wr(8'hB0, 8'h50);
    chk("status", 8'h00, {4'h0, sts});
    chk("alert", 8'h01, {7'h00, a_oe_n});
    wr(8'hB0, 8'h10);
    wt(8);
    chk("status", 8'h02, {4'h0, sts});
    flt <= 4'h0;
    wt(40);
    // clear pulse once the faults are gone
    wr(8'hB0, 8'h50);
    wr(8'hB0, 8'h10);
    chk("status", 8'h00, {4'h0, sts});
    flt <= 4'h1;
    wt(8);
    chk("stop", 8'h01, {7'h00, stp});
    flt <= 4'h0;
    wt(8);
    chk("stop", 8'h01, {7'h00, stp});
    wt(30);
    chk("stop", 8'h00, {7'h00, stp});
    mode <= 1'b1;
    flt <= 4'h4;
    wt(8);
    flt <= 4'h0;
    wt(40);
    chk("stop", 8'h01, {7'h00, stp});
    swen <= 1'b0;
    wt(8);
    swen <= 1'b1;
    wt(8);
    chk("stop", 8'h00, {7'h00, stp});
    wr(8'hB0, 8'h90);
    for (int c = 0; c < 4; c++) begin
      wr(8'hB1, 8'(c << 2));
      flt <= 4'h2;
      wt(8);
      chk("stop", 8'(c == 1 || c == 2), {7'h00, stp});
      flt <= 4'h0;
      wt(40);
      chk("stop", 8'(c == 2), {7'h00, stp});
      swen <= 1'b0;
      wt(8);
      swen <= 1'b1;
      wt(8);
    end
    complete_run();
  end
endmodule
bind ccr_top ccr_top_assertions chk_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_scl(i_scl), .i_switch_enable(i_switch_enable),
  .i_fault_detect(i_fault_detect), .i_phase_cmd(i_phase_cmd),
  .i_phase_both_off(i_phase_both_off), .o_sda_oe_n(o_sda_oe_n),
  .o_phase_drive_output(o_phase_drive_output),
  .o_phase_drive_output_mid(o_phase_drive_output_mid),
  .o_switching_stop(o_switching_stop), .o_fault_status(o_fault_status),
  .o_fault_alert_output_out(o_fault_alert_output_out),
  .o_fault_alert_output_oe_n(o_fault_alert_output_oe_n));
